// ---- hw/dtc_defines.vh ----
`ifndef DTC_DEFINES_VH
`define DTC_DEFINES_VH

// Register byte offsets
`define DTC_OFS_MR0 4'h0
`define DTC_OFS_MR1 4'h4
`define DTC_OFS_MR2 4'h8
`define DTC_OFS_STAT 4'hC

// Mode register images, bit positions as on the address pins
`define DTC_MR0_BL 1:0
`define DTC_MR0_CL 6:2
`define DTC_MR0_FAST 12
`define DTC_MR1_DLL_DIS 0
`define DTC_MR1_AL 4:3
`define DTC_MR1_NOM_A2 2
`define DTC_MR1_NOM_A6 6
`define DTC_MR1_NOM_A9 9
`define DTC_MR2_CWL 5:3
`define DTC_MR2_WR 10:9

// Writable bits and reset values
`define DTC_MR0_MASK 16'h107F
`define DTC_MR1_MASK 16'h025D
`define DTC_MR2_MASK 16'h0638
`define DTC_MR0_RST 16'h0014
`define DTC_MR1_RST 16'h0000
`define DTC_MR2_RST 16'h0000

// Burst modes
`define DTC_BL_8 2'h0
`define DTC_BL_OTF 2'h1
`define DTC_BL_BC4 2'h2

// Status bits
`define DTC_ST_VIOL 5

// Latencies in clock cycles
`define DTC_CWL_BASE 5'h05
`define DTC_ODTL_SUB 5'h02
`define DTC_ODTH4 3'h4
`define DTC_ODTH8 3'h6
`define DTC_CWN4_ADD 5'h04
`define DTC_CWN8_ADD 5'h06

`endif

// ---- hw/dtc_dly_line.v ----
`timescale 1ns/1ns
module dtc_dly_line
(
   input wire clk_i,
   input wire arst_n_i,
   input wire clr_i,
   input wire din_i,
   input wire [4:0] tap_i,
   output wire dout_o
);
   reg [31:0] stage_ff;

   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         stage_ff[0] <= 1'b0;
      else
         stage_ff[0] <= clr_i ? 1'b0 : din_i;
   end

   genvar gi;
   generate
      for (gi = 1; gi < 32; gi = gi + 1)
      begin : g_stage
         always @(posedge clk_i or negedge arst_n_i)
         begin
            if (!arst_n_i)
               stage_ff[gi] <= 1'b0;
            else
               stage_ff[gi] <= clr_i ? 1'b0 : stage_ff[gi-1];
         end
      end
   endgenerate

   // Stage k holds the sample taken k+1 edges ago
   assign dout_o = stage_ff[tap_i];
endmodule

// ---- hw/dtc_lat_ctr.v ----
`timescale 1ns/1ns
module dtc_lat_ctr
(
   input wire clk_i,
   input wire arst_n_i,
   input wire clr_i,
   input wire load_i,
   input wire [4:0] load_val_i,
   output wire expire_o,
   output wire busy_o
);
   reg [4:0] cnt_ff;

   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         cnt_ff <= 5'h00;
      else if (clr_i)
         cnt_ff <= 5'h00;
      else if (load_i)
         cnt_ff <= load_val_i;
      else if (cnt_ff != 5'h00)
         cnt_ff <= cnt_ff - 5'h01;
   end

   // Owner acts on the edge that follows, i.e. load_val edges after the load
   assign expire_o = (cnt_ff == 5'h01) & ~load_i;
   assign busy_o = (cnt_ff != 5'h00);
endmodule

// ---- hw/dtc_odt_ctrl.v ----
// Decided for this implementation: register access over Wishbone and the address map.
`timescale 1ns/1ns
`include "dtc_defines.vh"
module dtc_odt_ctrl
(
   input wire clk_i,
   input wire arst_n_i,
   input wire odt_i,
   input wire cke_i,
   input wire bank_open_i,
   input wire self_refresh_i,
   input wire wr_cmd_i,
   input wire wr_bc4_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output wire [31:0] wb_dat_o,
   output wire wb_ack_o,
   output wire term_en_o,
   output wire [2:0] rtt_code_o,
   output wire rtt_wr_sel_o,
   output wire async_mode_o,
   output wire dll_run_o
);
   reg [15:0] mr0_ff;
   reg [15:0] mr1_ff;
   reg [15:0] mr2_ff;
   reg ack_ff;
   reg [31:0] dat_ff;
   reg term_ff;
   reg wr_sel_ff;
   reg [2:0] rtt_code_ff;
   reg dll_run_ff;
   reg pd_ff;
   reg pd_act_ff;
   reg odt_q_ff;
   reg [2:0] hold_ff;
   reg viol_ff;
   reg nxt_term;
   reg nxt_wr_sel;
   reg [2:0] nxt_hold;
   reg [31:0] nxt_dat;

   wire [1:0] bl_mode;
   wire [4:0] cl_val;
   wire [1:0] al_sel;
   wire [2:0] cwl_sel;
   wire [2:0] rtt_nom;
   wire [1:0] rtt_wr;
   wire dll_dis;
   wire odt_en;
   wire dyn_en;
   wire [4:0] odtl;
   wire [4:0] tap;
   wire wr_bc4;
   wire [4:0] cwn;
   wire odt_tap;
   wire cnw_tap;
   wire cwn_expire;
   wire req;
   wire wr_hit;
   wire frozen;
   wire [15:0] stat;

   function [15:0] dtc_merge;
      input [15:0] old_val;
      input [15:0] new_val;
      input [1:0] sel;
      input [15:0] mask;
      reg [15:0] m;
      begin
         m = old_val;
         if (sel[0])
            m[7:0] = new_val[7:0];
         if (sel[1])
            m[15:8] = new_val[15:8];
         dtc_merge = m & mask;
      end
   endfunction

   function [4:0] dtc_wl;
      input [2:0] cwl;
      input [1:0] al;
      input [4:0] cl;
      reg [4:0] al_cyc;
      begin
         case (al)
            2'h1: al_cyc = cl - 5'h01;
            2'h2: al_cyc = cl - 5'h02;
            default: al_cyc = 5'h00;
         endcase
         dtc_wl = `DTC_CWL_BASE + {2'h0, cwl} + al_cyc;
      end
   endfunction

   assign bl_mode = mr0_ff[`DTC_MR0_BL];
   assign cl_val = mr0_ff[`DTC_MR0_CL];
   assign al_sel = mr1_ff[`DTC_MR1_AL];
   assign cwl_sel = mr2_ff[`DTC_MR2_CWL];
   assign dll_dis = mr1_ff[`DTC_MR1_DLL_DIS];

   // Nominal code packed as {A9, A6, A2}
   assign rtt_nom = {mr1_ff[`DTC_MR1_NOM_A9], mr1_ff[`DTC_MR1_NOM_A6],
      mr1_ff[`DTC_MR1_NOM_A2]};
   assign rtt_wr = mr2_ff[`DTC_MR2_WR];
   assign odt_en = (rtt_nom != 3'h0) | (rtt_wr != 2'h0);
   assign dyn_en = (rtt_wr != 2'h0);

   // ODTLon = ODTLoff = ODTLcnw = WL - 2, with WL = CWL + AL
   assign odtl = dtc_wl(cwl_sel, al_sel, cl_val) - `DTC_ODTL_SUB;
   assign tap = odtl - 5'h01;

   // Burst chop either fixed in the mode register or picked with the write
   assign wr_bc4 = (bl_mode == `DTC_BL_BC4) | ((bl_mode == `DTC_BL_OTF) & wr_bc4_i);
   assign cwn = odtl + (wr_bc4 ? `DTC_CWN4_ADD : `DTC_CWN8_ADD);

   // Pin history; the tap moves with the latency so AL applies to ODT too
   dtc_dly_line u_odt_dly
   (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .clr_i(self_refresh_i),
      .din_i(odt_i),
      .tap_i(tap),
      .dout_o(odt_tap)
   );

   // A delay line rather than a counter, so writes closer than WL keep their switch
   dtc_dly_line u_cnw_dly
   (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .clr_i(self_refresh_i | dll_dis),
      .din_i(wr_cmd_i & dyn_en),
      .tap_i(tap),
      .dout_o(cnw_tap)
   );

   // Restarted by each write, so back-to-back writes stretch the write strength
   dtc_lat_ctr u_cwn_ctr
   (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .clr_i(self_refresh_i | ~dyn_en),
      .load_i(wr_cmd_i),
      .load_val_i(cwn),
      .expire_o(cwn_expire),
      .busy_o()
   );

   // Power-down and DLL state
   assign frozen = pd_ff & ~pd_act_ff & ~mr0_ff[`DTC_MR0_FAST];

   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         pd_ff <= 1'b0;
         pd_act_ff <= 1'b0;
         dll_run_ff <= 1'b1;
      end
      else
      begin
         pd_ff <= ~cke_i;
         if (cke_i)
            pd_act_ff <= 1'b0;
         else if (!pd_ff)
            pd_act_ff <= bank_open_i;
         dll_run_ff <= ~dll_dis & ~frozen;
      end
   end

   // Termination on/off decision
   always @*
   begin
      nxt_term = 1'b0;
      if (self_refresh_i || !odt_en || dll_dis)
         nxt_term = 1'b0;
      else if (!dll_run_ff)
         nxt_term = odt_i;
      else
         nxt_term = odt_tap;
   end

   // Strength selection; a new switch-in wins over an expiring switch-back
   always @*
   begin
      nxt_wr_sel = wr_sel_ff;
      if (self_refresh_i || !dyn_en || dll_dis)
         nxt_wr_sel = 1'b0;
      else if (cnw_tap)
         nxt_wr_sel = 1'b1;
      else if (cwn_expire)
         nxt_wr_sel = 1'b0;
   end

   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         term_ff <= 1'b0;
         wr_sel_ff <= 1'b0;
         rtt_code_ff <= 3'h0;
      end
      else
      begin
         term_ff <= nxt_term;
         wr_sel_ff <= nxt_wr_sel;
         rtt_code_ff <= nxt_wr_sel ? {1'b0, rtt_wr} : rtt_nom;
      end
   end

   // Hold-time monitor for the controller's ODT pulse widths
   always @*
   begin
      nxt_hold = 3'h0;
      if (odt_i && !self_refresh_i)
      begin
         if (!odt_q_ff)
            nxt_hold = `DTC_ODTH4 - 3'h1;
         else if (hold_ff != 3'h0)
            nxt_hold = hold_ff - 3'h1;
         if (wr_cmd_i && wr_bc4 && nxt_hold < `DTC_ODTH4 - 3'h1)
            nxt_hold = `DTC_ODTH4 - 3'h1;
         if (wr_cmd_i && !wr_bc4)
            nxt_hold = `DTC_ODTH8 - 3'h1;
      end
   end

   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         odt_q_ff <= 1'b0;
         hold_ff <= 3'h0;
      end
      else
      begin
         odt_q_ff <= odt_i & ~self_refresh_i;
         hold_ff <= nxt_hold;
      end
   end

   // Wishbone slave: one wait state, write lands on the edge that samples ack
   assign req = wb_cyc_i & wb_stb_i;
   assign wr_hit = req & wb_we_i & ack_ff;

   assign stat = {5'h00, rtt_code_ff, 2'h0, viol_ff, odt_en, dll_run_ff,
      ~dll_run_ff & ~dll_dis, wr_sel_ff, term_ff};

   always @*
   begin
      nxt_dat = 32'h00000000;
      case (wb_adr_i)
         `DTC_OFS_MR0: nxt_dat = {16'h0000, mr0_ff};
         `DTC_OFS_MR1: nxt_dat = {16'h0000, mr1_ff};
         `DTC_OFS_MR2: nxt_dat = {16'h0000, mr2_ff};
         `DTC_OFS_STAT: nxt_dat = {16'h0000, stat};
         default: nxt_dat = 32'h00000000;
      endcase
   end

   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h00000000;
      end
      else
      begin
         ack_ff <= req & ~ack_ff;
         if (req && !ack_ff && !wb_we_i)
            dat_ff <= nxt_dat;
         else if (!req)
            dat_ff <= 32'h00000000;
      end
   end

   // Mode changes take effect on the next edge; software must not change
   // latencies while ODT or writes are in flight
   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         mr0_ff <= `DTC_MR0_RST;
         mr1_ff <= `DTC_MR1_RST;
         mr2_ff <= `DTC_MR2_RST;
      end
      else if (wr_hit)
      begin
         if (wb_adr_i == `DTC_OFS_MR0)
            mr0_ff <= dtc_merge(mr0_ff, wb_dat_i[15:0], wb_sel_i[1:0], `DTC_MR0_MASK);
         if (wb_adr_i == `DTC_OFS_MR1)
            mr1_ff <= dtc_merge(mr1_ff, wb_dat_i[15:0], wb_sel_i[1:0], `DTC_MR1_MASK);
         if (wb_adr_i == `DTC_OFS_MR2)
            mr2_ff <= dtc_merge(mr2_ff, wb_dat_i[15:0], wb_sel_i[1:0], `DTC_MR2_MASK);
      end
   end

   // Sticky violation flag; a new violation wins over a write-one clear
   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         viol_ff <= 1'b0;
      else if (!odt_i && hold_ff != 3'h0 && !self_refresh_i)
         viol_ff <= 1'b1;
      else if (wr_hit && wb_adr_i == `DTC_OFS_STAT && wb_sel_i[0]
         && wb_dat_i[`DTC_ST_VIOL])
         viol_ff <= 1'b0;
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;
   assign term_en_o = term_ff;
   assign rtt_code_o = rtt_code_ff;
   assign rtt_wr_sel_o = wr_sel_ff;
   assign async_mode_o = ~dll_run_ff & ~dll_dis;
   assign dll_run_o = dll_run_ff;
endmodule

// ---- tb/dtc_ctl_model.sv ----
`timescale 1ns/1ns
module dtc_ctl_model
(
   input wire clk_i,
   input wire go_i,
   input wire [3:0] len_i,
   input wire wr_i,
   input wire bc4_i,
   input wire brk_i,
   output reg odt_o = 1'b0,
   output reg wr_cmd_o = 1'b0,
   output reg wr_bc4_o = 1'b0
);
   reg [3:0] cnt_ff = 4'h0;
   reg [3:0] stop_ff = 4'h0;
   wire [3:0] hold = (wr_i && !bc4_i) ? 4'h6 : 4'h4;
   always @(posedge clk_i)
   begin
      wr_cmd_o <= 1'b0;
      wr_bc4_o <= 1'b0;
      cnt_ff <= cnt_ff + 4'h1;
      if (go_i && !odt_o)
      begin
         // Write leaves with the ODT rise, so both holds count from one edge
         odt_o <= 1'b1;
         wr_cmd_o <= wr_i;
         wr_bc4_o <= bc4_i;
         cnt_ff <= 4'h0;
         stop_ff <= brk_i ? 4'h2 : (len_i > hold ? len_i : hold);
      end
      else if (odt_o && cnt_ff == stop_ff - 4'h1)
         odt_o <= 1'b0;
   end
endmodule

// ---- tb/dtc_odt_ctrl_bench.sv ----
`timescale 1ns/1ns
`include "dtc_defines.vh"
module dtc_odt_ctrl_bench;
   reg clk_i = 1'b0;
   reg arst_n_i = 1'b0;
   reg cke = 1'b1;
   reg bank = 1'b0;
   reg sr = 1'b0;
   reg cyc = 1'b0;
   reg stb = 1'b0;
   reg we = 1'b0;
   reg [3:0] adr = 4'h0;
   reg [3:0] sel = 4'h0;
   reg [31:0] dat = 32'h0;
   reg go = 1'b0;
   reg wr = 1'b0;
   reg bc4 = 1'b0;
   reg brk = 1'b0;
   reg [3:0] len = 4'h0;
   wire odt, wcmd, wbc4, ack, term, wsel, asy, dll;
   wire [31:0] rdat;
   wire [2:0] code;
   wire [1:0] mon = {wsel, term};
   int num_errors = 0;
   int checked = 0;
   int i;
   logic [15:0] q, n, d, c;
   int al_t[3] = '{1, 2, 3};
   int cwl_t[3] = '{0, 2, 1};
   int lat_t[3] = '{7, 8, 4};
   int bl_t[4] = '{0, 2, 1, 1};
   int otf_t[4] = '{0, 0, 1, 0};
   int dur_t[4] = '{6, 4, 4, 6};
   initial forever #2 clk_i = ~clk_i;
   dtc_ctl_model u_ctl(.clk_i(clk_i), .go_i(go), .len_i(len), .wr_i(wr), .bc4_i(bc4),
      .brk_i(brk), .odt_o(odt), .wr_cmd_o(wcmd), .wr_bc4_o(wbc4));
   dtc_odt_ctrl u_dut(.clk_i(clk_i), .arst_n_i(arst_n_i), .odt_i(odt), .cke_i(cke),
      .bank_open_i(bank), .self_refresh_i(sr), .wr_cmd_i(wcmd), .wr_bc4_i(wbc4),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .term_en_o(term), .rtt_code_o(code),
      .rtt_wr_sel_o(wsel), .async_mode_o(asy), .dll_run_o(dll));
   task chk(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e)
      begin
         num_errors++;
         $display("CHECK FAILED %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task wb(input logic w, input logic [3:0] a, input logic [15:0] v, input logic [3:0] s = 4'h3);
      int k;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      dat <= {16'h0, v};
      k = 0;
      do
      begin
         @(posedge clk_i);
         k++;
      end
      while (ack !== 1'b1 && k < 20);
      if (ack !== 1'b1)
         num_errors++;
      q = rdat[15:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // Pulse the controller, then time the rise and width of the watched output
   task meas(input int s, input logic [3:0] l, input logic w, input logic b, input logic x);
      int k;
      @(posedge clk_i);
      len <= l;
      wr <= w;
      bc4 <= b;
      brk <= x;
      go <= 1'b1;
      n = 16'h0;
      do
      begin
         @(posedge clk_i);
         go <= 1'b0;
         #1;
         n++;
      end
      while (mon[s] !== 1'b1 && n < 20);
      c = {13'h0, code};
      d = 16'h0;
      while (mon[s] === 1'b1 && d < 20)
      begin
         @(posedge clk_i);
         #1;
         d++;
      end
      for (k = 0; k < 30 && (odt | term) !== 1'b0; k++)
         @(posedge clk_i);
   endtask
   task t_reg;
      wb(0, `DTC_OFS_MR0, 0); chk(q, 16'h0014);
      wb(0, `DTC_OFS_MR1, 0); chk(q, 16'h0000);
      wb(1, `DTC_OFS_MR2, 16'hFFFF, 4'h1);
      wb(0, `DTC_OFS_MR2, 0); chk(q, 16'h0038);
      wb(1, 4'h2, 16'hFFFF);
      wb(0, 4'h2, 0); chk(q, 16'h0000);
      wb(1, `DTC_OFS_MR2, 0);
      wb(0, `DTC_OFS_STAT, 0); chk(q, 16'h0008);
   endtask
   task t_sync;
      meas(0, 5, 1, 0, 0); chk(n, 20);
      wb(1, `DTC_OFS_MR1, 16'h0004);
      wb(0, `DTC_OFS_STAT, 0); chk(q, 16'h0118);
      meas(0, 5, 0, 0, 0); chk(n, 5);
      chk(d, 5);
      chk(c, 16'h0001);
      for (i = 0; i < 3; i++)
      begin
         wb(1, `DTC_OFS_MR1, 16'h0004 | 16'(al_t[i] << 3));
         wb(1, `DTC_OFS_MR2, 16'(cwl_t[i] << 3));
         meas(0, 4, 0, 0, 0); chk(n, 16'(lat_t[i] + 2));
      end
   endtask
   task t_dyn;
      wb(1, `DTC_OFS_MR2, 16'h0200);
      wb(1, `DTC_OFS_MR1, 16'h0040);
      for (i = 0; i < 4; i++)
      begin
         wb(1, `DTC_OFS_MR0, 16'h0014 | 16'(bl_t[i]));
         meas(1, 8, 1, 1'(otf_t[i]), 0); chk(n, 5);
         chk(d, 16'(dur_t[i]));
         chk(c, 16'h0001);
         chk({13'h0, code}, 16'h0002);
      end
      wb(1, `DTC_OFS_MR0, 16'h0014);
   endtask
   task t_pwr;
      @(posedge clk_i);
      sr <= 1'b1;
      meas(0, 5, 0, 0, 0); chk(n, 20);
      @(posedge clk_i);
      sr <= 1'b0;
      cke <= 1'b0;
      for (i = 0; i < 40 && asy !== 1'b1; i++)
         @(posedge clk_i);
      chk({15'h0, dll}, 16'h0000);
      meas(0, 4, 0, 0, 0); chk(n, 2);
      @(posedge clk_i);
      cke <= 1'b1;
      for (i = 0; i < 40 && dll !== 1'b1; i++)
         @(posedge clk_i);
      wb(1, `DTC_OFS_MR0, 16'h1014);
      cke <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk({14'h0, dll, asy}, 16'h0002);
      cke <= 1'b1;
      // Active power-down keeps the DLL even with slow exit selected
      wb(1, `DTC_OFS_MR0, 16'h0014);
      bank <= 1'b1;
      cke <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk({14'h0, dll, asy}, 16'h0002);
      cke <= 1'b1;
      bank <= 1'b0;
   endtask
   task t_hold;
      meas(0, 4, 0, 0, 1);
      wb(0, `DTC_OFS_STAT, 0); chk({15'h0, q[5]}, 16'h0001);
      wb(1, `DTC_OFS_STAT, 16'h0020);
      wb(0, `DTC_OFS_STAT, 0); chk({15'h0, q[5]}, 16'h0000);
      // DLL-off as the controller must set it up: both strength fields cleared
      wb(1, `DTC_OFS_MR2, 16'h0000);
      wb(1, `DTC_OFS_MR1, 16'h0001);
      meas(1, 5, 1, 0, 0); chk(n, 20);
      wb(0, `DTC_OFS_STAT, 0); chk(q, 16'h0000);
   endtask
   task stop_test;
      $display("Errors %0d in %0d checks", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (8) @(posedge clk_i);
      arst_n_i <= 1'b1;
      t_reg;
      t_sync;
      t_dyn;
      t_pwr;
      t_hold;
      stop_test;
   end
   initial
   begin
      #100000;
      num_errors++;
      stop_test;
   end
endmodule

// ---- tb/dtc_odt_ctrl_props.sv ----
`timescale 1ns/1ns
module dtc_odt_ctrl_props
(
   input wire clk_i,
   input wire arst_n_i,
   input wire odt_i,
   input wire self_refresh_i,
   input wire wr_cmd_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire wb_ack_o,
   input wire term_en_o,
   input wire [2:0] rtt_code_o,
   input wire rtt_wr_sel_o,
   input wire async_mode_o,
   input wire dll_run_o
);
   reg cwl_z_ff;
   reg al_z_ff;
   wire lat3 = cwl_z_ff & al_z_ff;
   // Latency checks assume CWL=5 and AL=0, so follow the bus writes
   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         cwl_z_ff <= 1'b1;
         al_z_ff <= 1'b1;
      end
      else if (wb_ack_o && wb_we_i && wb_sel_i[0])
      begin
         if (wb_adr_i == 4'h8)
            cwl_z_ff <= wb_dat_i[5:3] == 3'h0;
         if (wb_adr_i == 4'h4)
            al_z_ff <= wb_dat_i[4:3] == 2'h0;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   sr_off_a: assert property (self_refresh_i |=> !term_en_o)
      else $error("termination on in self-refresh");
   wr_code_a: assert property (rtt_wr_sel_o
      |-> !rtt_code_o[2] && rtt_code_o[1:0] != 2'h0)
      else $error("bad write strength code");
   // Frozen DLL: termination may only be on if the pin was high one edge before
   async_odt_a: assert property ($past(async_mode_o) && term_en_o |-> $past(odt_i))
      else $error("async termination not following odt");
   ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus ack missing");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus ack too long");
   // Output sampled one edge after it was set, so the pin is one edge further back
   on_lat_a: assert property (term_en_o && lat3 && !async_mode_o
      |-> $past(odt_i, 4))
      else $error("termination not following odt");
   cnw_a: assert property ($rose(rtt_wr_sel_o) && lat3 |-> $past(wr_cmd_i, 4))
      else $error("write strength at wrong time");
   cwn_a: assert property ($fell(rtt_wr_sel_o) && lat3
      |-> $past(wr_cmd_i, 8) || $past(wr_cmd_i, 10))
      else $error("nominal strength at wrong time");
   cover property ($rose(term_en_o));
   cover property ($rose(rtt_wr_sel_o));
   cover property (async_mode_o && term_en_o);
endmodule
bind dtc_odt_ctrl dtc_odt_ctrl_props u_props(.clk_i(clk_i), .arst_n_i(arst_n_i), .odt_i(odt_i),
   .self_refresh_i(self_refresh_i), .wr_cmd_i(wr_cmd_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_ack_o(wb_ack_o), .term_en_o(term_en_o), .rtt_code_o(rtt_code_o),
   .rtt_wr_sel_o(rtt_wr_sel_o), .async_mode_o(async_mode_o), .dll_run_o(dll_run_o));
